/* File: keypad_navigator.sv */
// Front panel navigation, view and edit controller
`timescale 1ns/1ps
module keypad_navigator #(
   parameter int DEB_CYCLES = keypad_pkg::DEBOUNCE_CYCLES,
   parameter int HOLD_CYCLES = keypad_pkg::LIMIT_HOLD_CYCLES,
   parameter int DELAY_CYCLES = keypad_pkg::REPEAT_DELAY_CYCLES,
   parameter int PERIOD_CYCLES = keypad_pkg::REPEAT_PERIOD_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Operator keys and access level
   input keypad_pkg::keys_t keys_raw,
   input wire logic access_all,
   // Parameter store and drive
   input keypad_pkg::drive_status_t drive_status,
   input keypad_pkg::param_info_t info,
   output keypad_pkg::param_write_t wr,
   // Display
   output keypad_pkg::disp_mode_t mode,
   output keypad_pkg::drive_status_t status_code,
   output logic [keypad_pkg::MENU_W-1:0] menu,
   output logic [keypad_pkg::PARAM_W-1:0] param,
   output logic signed [31:0] shown_value,
   output logic [2:0] digit,
   output logic flash_digit,
   output logic flash_all,
   output logic dashes,
   // Help scrolling and drive commands
   output logic help_up,
   output logic help_down,
   output logic stop_req,
   output logic reset_req
);
   localparam logic [4:0] MENU_TOP = 5'(keypad_pkg::MENU_MAX);

   if (HOLD_CYCLES < 1 || DELAY_CYCLES < 1 || PERIOD_CYCLES < 1)
   begin : g_chk
      $error("Timing counts must be at least 1");
   end

   function automatic logic signed [32:0] pow10(input logic [2:0] n);
      case (n)
         3'h0: return 33'sh000000001;
         3'h1: return 33'sh00000000A;
         3'h2: return 33'sh000000064;
         3'h3: return 33'sh0000003E8;
         3'h4: return 33'sh000002710;
         3'h5: return 33'sh0000186A0;
         3'h6: return 33'sh0000F4240;
         default: return 33'sh000000001;
      endcase
   endfunction : pow10

   function automatic logic [2:0] digits_of(input logic signed [31:0] v);
      logic [2:0] n;
      n = 3'h1;
      for (int i = 1; i < keypad_pkg::DIGIT_MAX; i++)
         if (33'(v) >= pow10(3'(i)))
            n = 3'(i + 1);
      return n;
   endfunction : digits_of

   keypad_pkg::keys_t keys;
   keypad_pkg::keys_t prev;
   keypad_pkg::keys_t press;
   logic rep;
   logic rep_first;
   logic [31:0] rep_cnt;
   logic [3:0] acc_cnt;
   logic [1:0] acc_lvl;
   logic [1:0] pend;
   logic [keypad_pkg::PARAM_W-1:0] mem_rdata;
   logic [keypad_pkg::MENU_W-1:0] next_menu;
   logic [keypad_pkg::PARAM_W-1:0] next_param;
   logic signed [31:0] edit_value;
   logic signed [31:0] over_limit;
   logic over;
   logic [31:0] over_cnt;
   logic view;
   logic both_ud;
   logic both_lr;
   logic up_step;
   logic down_step;
   logic right_step;
   logic left_step;
   logic adjusting;
   logic out_of_range;
   logic digit_ok;
   logic [2:0] ndig;
   logic signed [32:0] step_val;
   logic signed [32:0] cand_up;
   logic signed [32:0] cand_dn;

   key_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
      .mclk(mclk),
      .nrst(nrst),
      .raw(keys_raw),
      .keys(keys)
   );

   // Restore reads the new menu while writes track the current one
   menu_param_mem u_mem (
      .mclk(mclk),
      .nrst(nrst),
      .we(pend == 2'h0),
      .waddr(menu),
      .wdata(param),
      .raddr(menu),
      .rdata(mem_rdata)
   );

   assign press = keypad_pkg::keys_t'(keys & ~prev);
   assign view = (mode == keypad_pkg::MODE_VIEW);
   assign both_ud = keys.up && keys.down && (press.up || press.down);
   assign both_lr = keys.left && keys.right && (press.left || press.right);
   assign up_step = keys.up && !keys.down && (press.up || rep);
   assign down_step = keys.down && !keys.up && (press.down || rep);
   assign right_step = keys.right && !keys.left && (press.right || rep);
   assign left_step = keys.left && !keys.right && (press.left || rep);
   assign adjusting = keys.up || keys.down;
   assign out_of_range = info.value < keypad_pkg::VIEW_MIN ||
                         info.value > keypad_pkg::VIEW_MAX;
   assign digit_ok = !info.is_text && info.max > 32'sh00000009; // R12
   assign ndig = digits_of(info.max); // R12
   assign step_val = (digit == 3'h0) ? pow10({1'b0, acc_lvl}) : pow10(digit);
   assign cand_up = 33'(edit_value) + step_val;
   assign cand_dn = 33'(edit_value) - step_val;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         prev <= '0;
      else
         prev <= keys;
   end

   // Auto-repeat for a held joypad direction
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         rep_cnt <= '0;
         rep_first <= 1'b1;
         rep <= 1'b0;
      end
      else
      begin
         rep <= 1'b0;
         if (!(keys.up || keys.down || keys.left || keys.right) ||
             (press.up || press.down || press.left || press.right))
         begin
            rep_cnt <= '0;
            rep_first <= 1'b1;
         end
         else if (rep_cnt == (rep_first ? 32'(DELAY_CYCLES - 1) :
                              32'(PERIOD_CYCLES - 1)))
         begin
            rep_cnt <= '0;
            rep_first <= 1'b0;
            rep <= 1'b1;
         end
         else
            rep_cnt <= rep_cnt + 1'b1;
      end
   end

   // Step size grows while the least digit is held
   always_ff @(posedge mclk)
   begin
      if (!nrst || !adjusting || press.up || press.down)
      begin
         acc_cnt <= '0;
         acc_lvl <= '0;
      end
      else if (rep && digit == 3'h0 && mode == keypad_pkg::MODE_EDIT)
      begin
         if (acc_cnt == 4'(keypad_pkg::ACCEL_REPEATS - 1))
         begin
            acc_cnt <= '0;
            if (acc_lvl != keypad_pkg::ACCEL_TOP)
               acc_lvl <= acc_lvl + 1'b1; // R16
         end
         else
            acc_cnt <= acc_cnt + 1'b1;
      end
   end

   // Display mode sequencing
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         mode <= keypad_pkg::MODE_STATUS;
      else if (press.help)
         mode <= (mode == keypad_pkg::MODE_HELP) ? keypad_pkg::MODE_VIEW :
                 keypad_pkg::MODE_HELP; // R21
      else if (press.mode)
      begin
         case (mode) // R20
            keypad_pkg::MODE_STATUS: mode <= keypad_pkg::MODE_VIEW;
            keypad_pkg::MODE_VIEW: mode <= out_of_range ?
               keypad_pkg::MODE_STATUS : keypad_pkg::MODE_EDIT; // R2
            keypad_pkg::MODE_EDIT: mode <= keypad_pkg::MODE_STATUS;
            default: mode <= mode;
         endcase
      end
   end

   always_comb
   begin
      next_menu = menu;
      next_param = param;
      if (!access_all)
         next_menu = keypad_pkg::MENU_RESET; // R9
      else if (view && pend == 2'h0)
      begin
         if (both_lr)
            next_menu = keypad_pkg::MENU_RESET; // R8
         else if (right_step)
            next_menu = (menu < MENU_TOP) ? menu + 1'b1 :
                        (press.right ? keypad_pkg::MENU_RESET : menu); // R6
         else if (left_step)
            next_menu = (menu != 5'h00) ? menu - 1'b1 :
                        (press.left ? MENU_TOP : menu); // R7
      end
      if (view && pend == 2'h0 && next_menu == menu)
      begin
         if (both_ud)
            next_param = keypad_pkg::PARAM_RESET; // R5
         else if (up_step)
            next_param = (param < info.top) ? param + 1'b1 :
                         (press.up ? keypad_pkg::PARAM_RESET : param); // R3
         else if (down_step)
            next_param = (param != 8'h00) ? param - 1'b1 :
                         (press.down ? info.top : param); // R4
      end
   end

   // Menu and parameter position with per-menu restore
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         menu <= keypad_pkg::MENU_RESET;
         param <= keypad_pkg::PARAM_RESET;
         pend <= 2'h0;
      end
      else
      begin
         menu <= next_menu;
         if (next_menu != menu)
            pend <= keypad_pkg::RESTORE_WAIT;
         else if (pend != 2'h0)
            pend <= pend - 1'b1;
         if (pend == 2'h1)
            param <= mem_rdata; // R10
         else if (next_menu == menu)
            param <= next_param;
      end
   end

   // Value editing, digit selection and limit handling
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         edit_value <= '0;
         over_limit <= '0;
         over <= 1'b0;
         over_cnt <= '0;
         digit <= 3'h0;
         wr <= '0;
      end
      else
      begin
         wr.wr <= 1'b0;
         if (view && press.mode && !press.help)
         begin
            edit_value <= info.value;
            digit <= 3'h0;
            over <= 1'b0;
         end
         else if (mode != keypad_pkg::MODE_EDIT)
            over <= 1'b0;
         else if (both_ud)
         begin
            edit_value <= '0; // R19
            wr <= '{wr: 1'b1, value: 32'sh00000000};
            over <= 1'b0;
         end
         else if (over)
         begin
            if (!adjusting)
               over <= 1'b0; // R18
            else if (over_cnt == 32'(HOLD_CYCLES - 1))
            begin
               edit_value <= over_limit; // R18
               wr <= '{wr: 1'b1, value: over_limit};
               over <= 1'b0;
            end
            else
               over_cnt <= over_cnt + 1'b1;
         end
         else if (up_step)
         begin
            if (cand_up <= 33'(info.max))
            begin
               edit_value <= 32'(cand_up); // R11 R17
               wr <= '{wr: 1'b1, value: 32'(cand_up)};
            end
            else if (digit == 3'h0)
            begin
               edit_value <= info.max; // R16
               wr <= '{wr: 1'b1, value: info.max};
            end
            else
            begin
               over <= 1'b1; // R18
               over_limit <= info.max;
               over_cnt <= '0;
            end
         end
         else if (down_step)
         begin
            if (cand_dn >= 33'(info.min))
            begin
               edit_value <= 32'(cand_dn); // R11 R17
               wr <= '{wr: 1'b1, value: 32'(cand_dn)};
            end
            else if (digit == 3'h0)
            begin
               edit_value <= info.min; // R16
               wr <= '{wr: 1'b1, value: info.min};
            end
            else
            begin
               over <= 1'b1; // R18
               over_limit <= info.min;
               over_cnt <= '0;
            end
         end
         else if (digit_ok && press.right && !keys.left)
            digit <= (digit == 3'h0) ? ndig - 3'h1 : digit - 3'h1; // R13
         else if (digit_ok && press.left && !keys.right)
            digit <= (digit >= ndig - 3'h1) ? 3'h0 : digit + 3'h1; // R13
      end
   end

   // Display and command outputs
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         status_code <= keypad_pkg::status_inhibited;
         shown_value <= '0;
         flash_digit <= 1'b0;
         flash_all <= 1'b0;
         dashes <= 1'b0;
         help_up <= 1'b0;
         help_down <= 1'b0;
         stop_req <= 1'b0;
         reset_req <= 1'b0;
      end
      else
      begin
         status_code <= drive_status; // R1
         shown_value <= (mode != keypad_pkg::MODE_EDIT) ? info.value :
                        (over ? over_limit : edit_value);
         flash_digit <= mode == keypad_pkg::MODE_EDIT && !info.is_text &&
                        (!adjusting || over); // R14 R15
         flash_all <= mode == keypad_pkg::MODE_EDIT && info.is_text &&
                      !adjusting; // R14
         dashes <= mode != keypad_pkg::MODE_EDIT && out_of_range; // R2
         help_up <= mode == keypad_pkg::MODE_HELP && up_step; // R21
         help_down <= mode == keypad_pkg::MODE_HELP && down_step; // R21
         stop_req <= press.stop;
         reset_req <= press.stop; // R22
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   menu_wrap_up_a: assert property ( // R6
      view && access_all && pend == 2'h0 && press.right && !keys.left &&
      menu == MENU_TOP |=> menu == 5'h00)
      else $error("Right press at top menu did not wrap");
   menu_wrap_down_a: assert property ( // R7
      view && access_all && pend == 2'h0 && press.left && !keys.right &&
      menu == 5'h00 |=> menu == MENU_TOP)
      else $error("Left press at menu zero did not wrap");
   menu_lock_a: assert property ( // R9
      !access_all |=> menu == 5'h00)
      else $error("Menu left zero without access");
   menu_zero_a: assert property ( // R8
      view && access_all && pend == 2'h0 && both_lr |=> menu == 5'h00)
      else $error("Left and Right did not select menu zero");
   param_wrap_up_a: assert property ( // R3
      view && pend == 2'h0 && next_menu == menu && press.up && !keys.down &&
      param == info.top |=> param == 8'h00)
      else $error("Up press at top parameter did not wrap");
   param_wrap_down_a: assert property ( // R4
      view && pend == 2'h0 && next_menu == menu && press.down && !keys.up &&
      param == 8'h00 |=> param == $past(info.top))
      else $error("Down press at parameter zero did not wrap");
   param_zero_a: assert property ( // R5
      view && pend == 2'h0 && next_menu == menu && both_ud |=> param == 8'h00)
      else $error("Up and Down did not select parameter zero");
   reset_req_a: assert property ( // R22
      press.stop |=> reset_req && stop_req)
      else $error("Stop press gave no reset request");
   edit_clear_a: assert property ( // R19
      mode == keypad_pkg::MODE_EDIT && both_ud && !press.mode && !press.help
      |=> wr.wr && wr.value == 32'sh00000000 ##1 shown_value == 32'sh00000000)
      else $error("Up and Down did not zero the edited value");
   limit_hold_a: assert property ( // R18
      mode == keypad_pkg::MODE_EDIT && over && adjusting && !both_ud &&
      over_cnt == 32'(HOLD_CYCLES - 1) |=> wr.wr && wr.value == $past(over_limit))
      else $error("Held limit was not written");
   steady_edit_a: assert property ( // R15
      (mode == keypad_pkg::MODE_EDIT && adjusting && !over) [*2]
      |-> !flash_digit && !flash_all)
      else $error("Display flashed during in-range adjustment");
endmodule : keypad_navigator

/* File: keypad_pkg.sv */
// Constants, types and contract list for the keypad parameter navigator
// Contract
// R1: Status mode shows status code, last parameter
// R2: View range limits; outside shows dashes, locked
// R3: Up holds to top, single press wraps
// R4: Down holds to zero, single press wraps
// R5: Up and Down together select parameter zero
// R6: Right holds to menu 22, then wraps
// R7: Left holds to menu 0, then wraps
// R8: Left and Right together select menu 0
// R9: Menu change only with full access level
// R10: Each menu remembers its last parameter
// R11: Edit mode Up increases, Down decreases value
// R12: Digit selection only for numeric max above 9
// R13: Digit selection wraps at both ends
// R14: Idle edit flashes digit or whole text
// R15: Active in-range adjustment shows steady value
// R16: Least digit steps accelerate, stop at limits
// R17: Higher digits repeat steadily and carry over
// R18: Over limit flashes; release restores; hold writes
// R19: Up and Down together zero the value
// R20: Mode key cycles view, edit and status
// R21: Help key toggles help; Up/Down scroll only
// R22: Stop key press also requests drive reset
// R23: Debounced keys; close presses count as together
package keypad_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CYCLES_PER_MS = CLK_HZ / 1000;
   localparam int MENU_W = 5;
   localparam int PARAM_W = 8;
   localparam int MENU_MAX = 22;
   localparam int MENU_COUNT = MENU_MAX + 1;
   localparam logic [MENU_W-1:0] MENU_RESET = 5'h00;
   localparam logic [PARAM_W-1:0] PARAM_RESET = 8'h00;
   // -999,999 and 9,999,999
   localparam logic signed [31:0] VIEW_MIN = 32'shFFF0BDC1;
   localparam logic signed [31:0] VIEW_MAX = 32'sh0098967F;
   localparam int DIGIT_MAX = 7;
   localparam int LIMIT_HOLD_MS = 3000;
   localparam int LIMIT_HOLD_CYCLES = LIMIT_HOLD_MS * CYCLES_PER_MS;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CYCLES_PER_MS;
   localparam int REPEAT_DELAY_MS = 500;
   localparam int REPEAT_DELAY_CYCLES = REPEAT_DELAY_MS * CYCLES_PER_MS;
   localparam int REPEAT_PERIOD_MS = 100;
   localparam int REPEAT_PERIOD_CYCLES = REPEAT_PERIOD_MS * CYCLES_PER_MS;
   localparam int ACCEL_REPEATS = 8;
   localparam logic [1:0] ACCEL_TOP = 2'h3;
   localparam logic [1:0] RESTORE_WAIT = 2'h2;

   typedef struct packed {
      logic stop;
      logic help;
      logic mode;
      logic right;
      logic left;
      logic down;
      logic up;
   } keys_t;

   typedef enum logic [1:0] {
      MODE_STATUS = 2'b00,
      MODE_VIEW = 2'b01,
      MODE_EDIT = 2'b10,
      MODE_HELP = 2'b11
   } disp_mode_t;

   typedef enum logic [3:0] {
      status_inhibited = 4'b0000,
      status_ready = 4'b0001,
      status_stopped = 4'b0010,
      status_running = 4'b0011,
      status_scanning = 4'b0100,
      status_mains_loss = 4'b0101,
      status_decelerating = 4'b0110,
      status_dc_injection = 4'b0111,
      status_positioning = 4'b1000,
      status_tripped = 4'b1001,
      status_regen_active = 4'b1010
   } drive_status_t;

   typedef struct packed {
      logic signed [31:0] value;
      logic signed [31:0] max;
      logic signed [31:0] min;
      logic is_text;
      logic [PARAM_W-1:0] top;
   } param_info_t;

   typedef struct packed {
      logic wr;
      logic signed [31:0] value;
   } param_write_t;
endpackage : keypad_pkg

/* File: key_debounce.sv */
// Key debouncer that also merges near-simultaneous presses
`timescale 1ns/1ps
module key_debounce #(
   parameter int DEB_CYCLES = keypad_pkg::DEBOUNCE_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Raw and settled keys
   input keypad_pkg::keys_t raw,
   output keypad_pkg::keys_t keys
);
   localparam int CW = $clog2(DEB_CYCLES + 1);

   logic [CW-1:0] cnt;
   keypad_pkg::keys_t last;

   if (DEB_CYCLES < 1)
   begin : g_chk
      $error("DEB_CYCLES must be at least 1");
   end

   // Any change restarts the window, so keys landing inside it merge
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         last <= '0;
         cnt <= '0;
         keys <= '0;
      end
      else
      begin
         last <= raw;
         if (raw != last)
            cnt <= '0;
         else if (cnt != CW'(DEB_CYCLES - 1))
            cnt <= cnt + 1'b1;
         else
            keys <= last; // R23
      end
   end
endmodule : key_debounce

/* File: menu_param_mem.sv */
// Per-menu store of the last accessed parameter number
`timescale 1ns/1ps
module menu_param_mem #(
   parameter int DEPTH = keypad_pkg::MENU_COUNT,
   parameter int AW = keypad_pkg::MENU_W,
   parameter int DW = keypad_pkg::PARAM_W
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Registered read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   if (DEPTH > (1 << AW) || DEPTH < 1)
   begin : g_chk
      $error("DEPTH does not fit the address width");
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= '0;
      end
      else if (we && int'(waddr) < DEPTH)
         mem[waddr] <= wdata;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         rdata <= '0;
      else if (int'(raddr) < DEPTH)
         rdata <= mem[raddr];
      else
         rdata <= '0;
   end
endmodule : menu_param_mem

/* File: param_store_model.sv */
// Parameter store model answering the navigator's reads and writes
`timescale 1ns/1ps
module param_store_model
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Position and writes
   input wire logic [keypad_pkg::PARAM_W-1:0] param,
   input keypad_pkg::param_write_t wr,
   output keypad_pkg::param_info_t info
);
   logic signed [31:0] val [0:7];

   // Entry 3 holds a value beyond the displayable range
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 8; i++)
            val[i] <= 32'(i);
         val[3] <= 32'sh00989680;
      end
      else if (wr.wr)
         val[param[2:0]] <= wr.value;
   end

   // Entry 1 is numeric up to 150, entry 2 is text, others up to 9
   always_comb
   begin
      info.value = val[param[2:0]];
      info.max = (param == 8'h01) ? 32'sh00000096 : 32'sh00000009;
      info.min = 32'sh00000000;
      info.is_text = (param == 8'h02);
      info.top = 8'h05;
   end
endmodule : param_store_model

/* File: keypad_parameter_navigator_test.sv */
// Self-checking bench for the keypad parameter navigator
`timescale 1ns/1ps
module keypad_parameter_navigator_test;
   localparam logic [6:0] UP = 7'h01;
   localparam logic [6:0] DN = 7'h02;
   localparam logic [6:0] LT = 7'h04;
   localparam logic [6:0] RT = 7'h08;
   localparam logic [6:0] MD = 7'h10;
   localparam logic [6:0] HP = 7'h20;
   localparam logic [6:0] ST = 7'h40;
   logic mclk;
   logic nrst;
   logic access_all;
   keypad_pkg::keys_t keys_raw;
   keypad_pkg::drive_status_t drive_status;
   keypad_pkg::drive_status_t status_code;
   keypad_pkg::param_info_t info;
   keypad_pkg::param_write_t wr;
   keypad_pkg::disp_mode_t mode;
   logic [keypad_pkg::MENU_W-1:0] menu;
   logic [keypad_pkg::PARAM_W-1:0] param;
   logic signed [31:0] shown_value;
   logic [2:0] digit;
   logic flash_digit, flash_all, dashes;
   logic help_up, help_down, stop_req, reset_req;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_wr = 0;
   int n_hu = 0;
   int n_hd = 0;
   int n_sr = 0;
   int cyc = 0;

   keypad_navigator #(
      .DEB_CYCLES(4),
      .HOLD_CYCLES(20),
      .DELAY_CYCLES(8),
      .PERIOD_CYCLES(4)
   ) u_dut (
      .mclk(mclk), .nrst(nrst), .keys_raw(keys_raw),
      .access_all(access_all), .drive_status(drive_status),
      .info(info), .wr(wr), .mode(mode), .status_code(status_code),
      .menu(menu), .param(param), .shown_value(shown_value),
      .digit(digit), .flash_digit(flash_digit), .flash_all(flash_all),
      .dashes(dashes), .help_up(help_up), .help_down(help_down),
      .stop_req(stop_req), .reset_req(reset_req)
   );

   param_store_model u_store (
      .mclk(mclk), .nrst(nrst), .param(param), .wr(wr), .info(info)
   );

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Pulse counters and hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (wr.wr === 1'b1) n_wr++;
      if (help_up === 1'b1) n_hu++;
      if (help_down === 1'b1) n_hd++;
      if (stop_req === 1'b1 && reset_req === 1'b1) n_sr++;
      if (cyc == 6000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic press(input logic [6:0] k, input int n);
      keys_raw <= keypad_pkg::keys_t'(k);
      repeat (n) @(posedge mclk);
   endtask : press

   task automatic rel();
      keys_raw <= '0;
      repeat (14) @(posedge mclk);
   endtask : rel

   // Settled for six edges only, so the repeat delay never elapses
   task automatic tap(input logic [6:0] k);
      press(k, 6);
      rel();
   endtask : tap

   task automatic t_status();
      for (int i = 0; i < 11; i++)
      begin
         drive_status <= keypad_pkg::drive_status_t'(i[3:0]);
         repeat (3) @(posedge mclk);
         chk("status_code", 32'(i), status_code);
      end
      tap(ST);
      chk("stop_reset", 32'h1, n_sr);
      $display("test status done");
   endtask : t_status

   task automatic t_view();
      tap(MD);
      chk("mode", 32'h1, mode);
      tap(UP);
      chk("param", 32'h1, param);
      tap(DN);
      tap(DN);
      chk("param", 32'h5, param);
      tap(UP);
      chk("param", 32'h0, param);
      tap(UP);
      tap(UP);
      tap(UP | DN);
      chk("param", 32'h0, param);
      $display("test view done");
   endtask : t_view

   task automatic t_menu();
      tap(RT);
      chk("menu", 32'h0, menu);
      access_all <= 1'b1;
      tap(LT);
      chk("menu", 32'h16, menu);
      tap(RT);
      chk("menu", 32'h0, menu);
      tap(UP);
      tap(RT);
      chk("param", 32'h0, param);
      tap(UP);
      tap(UP);
      tap(LT | RT);
      chk("menu", 32'h0, menu);
      chk("param", 32'h1, param);
      press(RT, 150);
      chk("menu", 32'h16, menu);
      rel();
      tap(LT | RT);
      $display("test menu done");
   endtask : t_menu

   task automatic t_edit();
      tap(MD);
      chk("mode", 32'h2, mode);
      n_wr = 0;
      tap(UP);
      chk("shown", 32'h2, shown_value);
      chk("writes", 32'h1, n_wr);
      tap(DN);
      chk("shown", 32'h1, shown_value);
      tap(UP | DN);
      chk("shown", 32'h0, shown_value);
      chk("flash_digit", 32'h1, flash_digit);
      tap(RT);
      chk("digit", 32'h2, digit);
      tap(LT);
      chk("digit", 32'h0, digit);
      tap(RT);
      tap(UP);
      chk("shown", 32'h64, shown_value);
      press(UP, 10);
      chk("shown", 32'h96, shown_value);
      chk("flash_digit", 32'h1, flash_digit);
      rel();
      chk("shown", 32'h64, shown_value);
      n_wr = 0;
      press(UP, 34);
      rel();
      chk("shown", 32'h96, shown_value);
      chk("writes", 32'h1, n_wr);
      tap(MD);
      chk("mode", 32'h0, mode);
      chk("param", 32'h1, param);
      $display("test edit done");
   endtask : t_edit

   task automatic t_text_range();
      tap(MD);
      tap(UP);
      tap(MD);
      tap(RT);
      chk("digit", 32'h0, digit);
      chk("flash_all", 32'h1, flash_all);
      tap(MD);
      tap(MD);
      tap(UP);
      chk("dashes", 32'h1, dashes);
      tap(MD);
      chk("mode", 32'h0, mode);
      $display("test text and range done");
   endtask : t_text_range

   task automatic t_help();
      tap(MD);
      tap(HP);
      chk("mode", 32'h3, mode);
      n_hu = 0;
      tap(UP);
      chk("help_up", 32'h1, n_hu);
      n_hd = 0;
      tap(DN);
      chk("help_down", 32'h1, n_hd);
      tap(RT);
      chk("menu", 32'h0, menu);
      tap(HP);
      chk("mode", 32'h1, mode);
      $display("test help done");
   endtask : t_help

   initial
   begin
      nrst = 1'b0;
      keys_raw = '0;
      access_all = 1'b0;
      drive_status = keypad_pkg::status_inhibited;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
      t_status();
      t_view();
      t_menu();
      t_edit();
      t_text_range();
      t_help();
      summarize();
   end
endmodule : keypad_parameter_navigator_test
